// File: rsc_cfg.svh
// Constants for the reset and system control block.
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH
`define RSC_ADDR_MISC      4'hC
`define RSC_ADDR_STAT      4'h0
`define RSC_ADDR_IEN       4'h1
`define RSC_ADDR_ICLR      4'h2
`define RSC_BIT_POR        7
`define RSC_BIT_RISE       6
`define RSC_BIT_FALL       5
`define RSC_BIT_GATE       4
`define RSC_BIT_SFA        3
`define RSC_BIT_SFB        2
`define RSC_BIT_SM         1
`define RSC_BIT_WATCHDOG_ENABLE_BIT       0
`define RSC_MISC_RESET     8'h10
`define RSC_POR_SHORT      16
`define RSC_POR_LONG       4064
`define RSC_EXT_MIN_HALF   3
`define RSC_WATCHDOG_ENABLE_BIT_TICKS     8192
`define RSC_WATCHDOG_ENABLE_BIT_PRESCALE  1024
`define RSC_PLM_FAST       256
`define RSC_PLM_SLOW       4096
`define RSC_SLOW_DIV       16
`define RSC_EV_WATCHDOG_ENABLE_BIT        0
`define RSC_EV_EXTRST      1
`define RSC_EV_IRQ         2
`endif

// File: rsc_pkg.sv
// Types for the reset and system control block.
package rsc_pkg;
    typedef enum logic [1:0] {
        RSC_POR     = 2'b00,
        RSC_PINWAIT = 2'b01,
        RSC_RUN     = 2'b11,
        RSC_EXTRST  = 2'b10
    } rsc_state_e;
endpackage

// File: rsc_irq_detect.sv
// External interrupt pin synchroniser, edge detector and request latch.
`include "rsc_cfg.svh"
module rsc_irq_detect
    import rsc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic irqPinN,
    input  wire logic riseSel,
    input  wire logic fallSel,
    input  wire logic gate,
    input  wire logic ack,
    output logic      request,
    output logic      edgeSeen
);
    logic syncA_r, syncB_r, prev_r, latch_r;
    logic latch_nxt, fall, rise, hit;

    always_comb
    begin
        fall = prev_r & ~syncB_r; // R17
        rise = ~prev_r & syncB_r; // R17
        case ({riseSel, fallSel}) // R06
            2'b00:   hit = fall | ~syncB_r; // R17
            2'b01:   hit = fall;
            2'b10:   hit = rise;
            default: hit = fall | rise;
        endcase
        hit = hit & gate; // R07
        latch_nxt = latch_r;
        if (ack)
        begin
            latch_nxt = 1'b0; // R14
        end
        if (hit)
        begin
            latch_nxt = 1'b1; // R14
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            syncA_r <= 1'b1;
            syncB_r <= 1'b1;
            prev_r  <= 1'b1;
            latch_r <= 1'b0;
        end
        else
        begin
            syncA_r <= irqPinN; // R14
            syncB_r <= syncA_r;
            prev_r  <= syncB_r;
            latch_r <= latch_nxt;
        end
    end

    assign request  = latch_r;
    assign edgeSeen = hit;
endmodule

// File: rsc_reset_control.sv
// Reset sequencer, miscellaneous control register and interrupt pending.
//
// Our own choice: the strobed register port.
`include "rsc_cfg.svh"
// Notes on behaviour
// R01: Power-up reset held for delay after clock.
// R02: Delay is 16 or 4064 cycles option.
// R03: Stay in reset while pin low.
// R04: Pin low one and half cycles resets; the code needs the synchronised pin low for three clock cycles.
// R05: Bit 7 reads power-up reset flag.
// R06: Bits 6,5 choose interrupt pin sensitivity.
// R07: Bit 4 gates interrupt; resets to one.
// R08: Bit 3 picks modulator A period.
// R09: Bit 2 picks modulator B period.
// R10: Bit 1 divides system clock by sixteen.
// R11: Bit 0 shows and controls watchdog enable.
// R12: Watchdog timeout resets all, clears enable.
// R13: Masked requests stay pending until unmasked; the timer request is not latched here.
// R14: Pin synchronised, latched, cleared on service.
// R15: Slow select cleared by resets, stop.
// R16: Writing one starts or kicks watchdog.
// R17: Edges from successive samples; level repeats.
module rsc_reset_control
    import rsc_pkg::*;
#(
    parameter int PorDelay   = `RSC_POR_LONG,
    parameter int WdogPeriod = `RSC_WATCHDOG_ENABLE_BIT_TICKS * `RSC_WATCHDOG_ENABLE_BIT_PRESCALE
)
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       resetPinN,
    input  wire logic       irqPinN,
    input  wire logic       cpuMask,
    input  wire logic       irqAck,
    input  wire logic       timerReq,
    input  wire logic       stopEntry,
    input  wire logic [3:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdata,
    output logic            sysReset,
    output logic            extIrqPending,
    output logic            timerIrqPending,
    output logic            plmAPeriodSlow,
    output logic            plmBPeriodSlow,
    output logic            cpuClkEn,
    output logic            irqOut
);
    rsc_state_e state_r, state_nxt;
    logic [12:0] porCnt_r, porCnt_nxt;
    logic [1:0]  pinLowCnt_r, pinLowCnt_nxt;
    logic [22:0] wdogCnt_r, wdogCnt_nxt;
    logic [3:0]  divCnt_r, divCnt_nxt;
    logic [7:0]  misc_r, misc_nxt;
    logic [2:0]  stat_r, stat_nxt, ien_r, ien_nxt;
    logic [7:0]  rdata_r, rdata_nxt;
    logic        pinA_r, pinB_r;
    logic        sysReset_r, sysReset_nxt, porFlag_r, porFlag_nxt;
    logic        extPend_r, extPend_nxt, tmrPend_r, tmrPend_nxt;
    logic        clkEn_r, clkEn_nxt, irqOut_r, irqOut_nxt;
    logic        wdogFire, extReq, irqEdge, softRst;

    rsc_irq_detect u_irq (
        .clk      (clk),
        .rst      (rst),
        .irqPinN  (irqPinN),
        .riseSel  (misc_r[`RSC_BIT_RISE]),
        .fallSel  (misc_r[`RSC_BIT_FALL]),
        .gate     (misc_r[`RSC_BIT_GATE]),
        .ack      (irqAck),
        .request  (extReq),
        .edgeSeen (irqEdge)
    );

    always_comb
    begin
        state_nxt     = state_r;
        porCnt_nxt    = porCnt_r;
        pinLowCnt_nxt = pinB_r ? 2'h0 : pinLowCnt_r;
        porFlag_nxt   = porFlag_r;
        wdogFire      = misc_r[`RSC_BIT_WATCHDOG_ENABLE_BIT] &&
                        wdogCnt_r == 23'(WdogPeriod - 1);
        softRst       = wdogFire ||
                        (stopEntry && misc_r[`RSC_BIT_WATCHDOG_ENABLE_BIT]);
        if (!pinB_r && pinLowCnt_r != 2'(`RSC_EXT_MIN_HALF))
        begin
            pinLowCnt_nxt = pinLowCnt_r + 2'h1;
        end
        case (state_r)
            RSC_POR:
            begin
                porCnt_nxt = porCnt_r + 13'h1; // R01
                if (porCnt_r == 13'(PorDelay - 1)) // R02
                begin
                    state_nxt = pinB_r ? RSC_RUN : RSC_PINWAIT; // R03
                end
            end
            RSC_PINWAIT:
            begin
                if (pinB_r) // R03
                begin
                    state_nxt   = RSC_RUN;
                    porFlag_nxt = 1'b0; // R05
                end
            end
            RSC_RUN:
            begin
                porFlag_nxt = 1'b0; // R05
                if (pinLowCnt_r == 2'(`RSC_EXT_MIN_HALF)) // R04
                begin
                    state_nxt = RSC_EXTRST;
                end
                else if (softRst) // R12
                begin
                    state_nxt = RSC_EXTRST;
                end
            end
            RSC_EXTRST:
            begin
                if (pinB_r)
                begin
                    state_nxt = RSC_RUN;
                end
            end
            default:
            begin
                state_nxt = RSC_POR;
            end
        endcase
        sysReset_nxt = state_nxt != RSC_RUN;
    end

    always_comb
    begin
        misc_nxt  = misc_r;
        stat_nxt  = stat_r;
        ien_nxt   = ien_r;
        rdata_nxt = 8'h00;
        wdogCnt_nxt = misc_r[`RSC_BIT_WATCHDOG_ENABLE_BIT] ? wdogCnt_r + 23'h1 : 23'h0;
        if (regWr && regAddr == `RSC_ADDR_MISC)
        begin
            misc_nxt[6:1] = regWdata[6:1]; // R06
            if (regWdata[`RSC_BIT_WATCHDOG_ENABLE_BIT]) // R16
            begin
                misc_nxt[`RSC_BIT_WATCHDOG_ENABLE_BIT] = 1'b1;
                wdogCnt_nxt = 23'h0;
            end
        end
        if (regWr && regAddr == `RSC_ADDR_IEN)
        begin
            ien_nxt = regWdata[2:0];
        end
        if (regWr && regAddr == `RSC_ADDR_ICLR)
        begin
            stat_nxt = stat_r & ~regWdata[2:0];
        end
        if (stopEntry)
        begin
            misc_nxt[`RSC_BIT_SM] = 1'b0; // R15
        end
        if (sysReset_r)
        begin
            misc_nxt    = `RSC_MISC_RESET; // R07
            wdogCnt_nxt = 23'h0; // R12
        end
        misc_nxt[`RSC_BIT_POR] = porFlag_nxt; // R05
        stat_nxt[`RSC_EV_WATCHDOG_ENABLE_BIT] = stat_nxt[`RSC_EV_WATCHDOG_ENABLE_BIT] | wdogFire;
        stat_nxt[`RSC_EV_EXTRST] = stat_nxt[`RSC_EV_EXTRST] |
            (state_r == RSC_RUN && pinLowCnt_r == 2'(`RSC_EXT_MIN_HALF));
        stat_nxt[`RSC_EV_IRQ] = stat_nxt[`RSC_EV_IRQ] | irqEdge;
        if (regRd)
        begin
            case (regAddr)
                `RSC_ADDR_MISC: rdata_nxt = misc_r; // R05 R11
                `RSC_ADDR_STAT: rdata_nxt = {5'h00, stat_r};
                `RSC_ADDR_IEN:  rdata_nxt = {5'h00, ien_r};
                default:        rdata_nxt = 8'h00;
            endcase
        end
        irqOut_nxt  = |(stat_nxt & ien_nxt);
        // The external request stays latched while masked and surfaces when it clears; the timer request is not latched.
        extPend_nxt = extReq & ~cpuMask; // R13
        tmrPend_nxt = timerReq & ~cpuMask; // R13
        clkEn_nxt   = 1'b1;
        divCnt_nxt  = 4'h0;
        if (misc_r[`RSC_BIT_SM]) // R10
        begin
            divCnt_nxt = divCnt_r + 4'h1;
            clkEn_nxt  = divCnt_r == 4'(`RSC_SLOW_DIV - 1);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r     <= RSC_POR;
            porCnt_r    <= 13'h0;
            pinLowCnt_r <= 2'h0;
            pinA_r      <= 1'b0;
            pinB_r      <= 1'b0;
            porFlag_r   <= 1'b1;
            sysReset_r  <= 1'b1;
            wdogCnt_r   <= 23'h0;
            divCnt_r    <= 4'h0;
            misc_r      <= `RSC_MISC_RESET | 8'h80;
            stat_r      <= 3'h0;
            ien_r       <= 3'h0;
            rdata_r     <= 8'h00;
            extPend_r   <= 1'b0;
            tmrPend_r   <= 1'b0;
            clkEn_r     <= 1'b1;
            irqOut_r    <= 1'b0;
        end
        else
        begin
            pinA_r      <= resetPinN;
            pinB_r      <= pinA_r;
            state_r     <= state_nxt;
            porCnt_r    <= porCnt_nxt;
            pinLowCnt_r <= pinLowCnt_nxt;
            porFlag_r   <= porFlag_nxt;
            sysReset_r  <= sysReset_nxt;
            wdogCnt_r   <= wdogCnt_nxt;
            divCnt_r    <= divCnt_nxt;
            misc_r      <= misc_nxt;
            stat_r      <= stat_nxt;
            ien_r       <= ien_nxt;
            rdata_r     <= rdata_nxt;
            extPend_r   <= extPend_nxt;
            tmrPend_r   <= tmrPend_nxt;
            clkEn_r     <= clkEn_nxt;
            irqOut_r    <= irqOut_nxt;
        end
    end

    assign regRdata        = rdata_r;
    assign sysReset        = sysReset_r;
    assign extIrqPending   = extPend_r;
    assign timerIrqPending = tmrPend_r;
    assign plmAPeriodSlow  = misc_r[`RSC_BIT_SFA]; // R08
    assign plmBPeriodSlow  = misc_r[`RSC_BIT_SFB]; // R09
    assign cpuClkEn        = clkEn_r;
    assign irqOut          = irqOut_r;
endmodule

// File: rsc_reset_control_sva.sv
// Port assertions for the reset and system control block.
module rsc_reset_control_sva
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       resetPinN,
    input wire logic       irqPinN,
    input wire logic       cpuMask,
    input wire logic       irqAck,
    input wire logic       timerReq,
    input wire logic       stopEntry,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic [7:0] regRdata,
    input wire logic       sysReset,
    input wire logic       extIrqPending,
    input wire logic       timerIrqPending,
    input wire logic       plmAPeriodSlow,
    input wire logic       plmBPeriodSlow,
    input wire logic       cpuClkEn,
    input wire logic       irqOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    por_hold_a: assert property ($fell(rst) |-> sysReset[*8])
        else $error("Power-up reset too short.");
    pin_reset_a: assert property (
        !resetPinN[*8] ##1 !resetPinN[*2] |-> sysReset)
        else $error("Reset pin low but no reset.");
    pin_hold_a: assert property (
        sysReset && !$past(resetPinN, 2) |=> sysReset)
        else $error("Reset left while pin low.");
    misc_clear_a: assert property (
        sysReset[*3] |-> !plmAPeriodSlow && !plmBPeriodSlow && cpuClkEn)
        else $error("Control bits not cleared by reset.");
    misc_write_a: assert property (
        regWr && regAddr == 4'hC && !sysReset ##1 (!regWr && !sysReset)[*2]
        |-> {plmAPeriodSlow, plmBPeriodSlow} == $past(regWdata[3:2], 2))
        else $error("Period selects differ from write.");
    slow_tick_a: assert property (!cpuClkEn |-> ##[1:16] cpuClkEn)
        else $error("Slow clock enable missing.");
    mask_hold_a: assert property (
        cpuMask |=> !timerIrqPending && !extIrqPending)
        else $error("Request passed while masked.");
    timer_pend_a: assert property (
        !sysReset && timerReq && !cpuMask ##1 !sysReset |-> timerIrqPending)
        else $error("Timer request not pending.");
    ext_latch_a: assert property (
        !irqAck ##1 extIrqPending && !irqAck && !cpuMask && !sysReset
        |=> extIrqPending)
        else $error("External request lost before service.");
    read_idle_a: assert property (!$past(regRd) |-> regRdata == 8'h00)
        else $error("Read data outside read slot.");
endmodule

bind rsc_reset_control rsc_reset_control_sva i_sva (.*);

// File: rsc_partner.sv
// Model of the reset source and the CPU side that services requests.
module rsc_partner
#(
    parameter int AckDelay = 3
)
(
    input  wire logic clk,
    input  wire logic holdLow,
    input  wire logic pending,
    output logic      resetPinN,
    output logic      irqAck
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    initial
    begin
        resetPinN = 1'b1;
        irqAck = 1'b0;
    end
    always @(posedge clk)
    begin
        resetPinN <= !holdLow;
        irqAck <= pending && cnt == AckDelay;
        cnt <= (pending && !irqAck) ? cnt + 1 : 0;
    end
endmodule

// File: rsc_reset_control_tb.sv
// Self-checking testbench for the reset and system control block.
module rsc_reset_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import rsc_pkg::*;
    logic       clk = 0, rst = 1, irqPinN = 1, cpuMask = 1, timerReq = 0;
    logic       regWr = 0, regRd = 0, rdLat = 0, holdPin = 0, stopEntry = 0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00, regRdata, expV, v;
    logic       resetPinN, irqAck, sysReset, extIrqPending, timerIrqPending;
    logic       plmAPeriodSlow, plmBPeriodSlow, cpuClkEn, irqOut;
    logic [7:0] expQ[$];
    logic [31:0] seed = 32'd80725;
    int         fail_count = 0, n_tests = 0, k = 0;
    always #25 clk = ~clk;
    rsc_reset_control #(.PorDelay(16), .WdogPeriod(64)) i_dut (.*);
    rsc_partner i_cpu (.clk(clk), .holdLow(holdPin), .pending(extIrqPending),
        .resetPinN(resetPinN), .irqAck(irqAck));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic check(logic [7:0] seen, logic [7:0] want);
        n_tests++;
        if (seen !== want)
        begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [7:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        expQ.push_back(e);
        @(posedge clk);
        regRd <= 1'b0;
    endtask
    task automatic waitFor(logic s);
        repeat (300) if (sysReset !== s) @(negedge clk);
        check(sysReset, s);
    endtask
    task automatic pulseStop();
        @(posedge clk);
        stopEntry <= 1'b1;
        @(posedge clk);
        stopEntry <= 1'b0;
    endtask
    task automatic close_out();
        $display("Counts: %0d checks, %0d mismatches", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk) rdLat <= regRd;
    always @(negedge clk)
    begin
        if (rdLat)
        begin
            expV = expQ.pop_front();
            check(regRdata, expV);
        end
    end
    initial
    begin
        #(20000 * 50);
        fail_count++;
        close_out();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        waitFor(1'b0);
        rd(4'hC, 8'h10);
        rd(4'h5, 8'h00);
        $display("Test reset values done");
        repeat (4)
        begin
            v = rnd() & 8'h7E;
            wr(4'hC, v);
            rd(4'hC, v);
            @(negedge clk);
            check({plmAPeriodSlow, plmBPeriodSlow}, v[3:2]);
        end
        $display("Test control register done");
        wr(4'hC, 8'h11);
        rd(4'hC, 8'h11);
        repeat (40) @(posedge clk);
        wr(4'hC, 8'h11);
        repeat (40) @(negedge clk);
        check(sysReset, 1'b0);
        waitFor(1'b1);
        waitFor(1'b0);
        rd(4'hC, 8'h10);
        $display("Test watchdog done");
        wr(4'hC, 8'h12);
        repeat (4) @(negedge clk);
        k = 0;
        repeat (32)
        begin
            @(negedge clk);
            k += cpuClkEn;
        end
        check(8'(k), 8'h02);
        pulseStop();
        rd(4'hC, 8'h10);
        @(negedge clk);
        check(cpuClkEn, 1'b1);
        wr(4'hC, 8'h11);
        pulseStop();
        waitFor(1'b1);
        waitFor(1'b0);
        rd(4'hC, 8'h10);
        $display("Test slow clock and stop done");
        wr(4'hC, 8'h12);
        holdPin <= 1'b1;
        waitFor(1'b1);
        repeat (20) @(negedge clk);
        check(sysReset, 1'b1);
        holdPin <= 1'b0;
        waitFor(1'b0);
        rd(4'hC, 8'h10);
        wr(4'h1, 8'h02);
        repeat (3) @(negedge clk);
        check(irqOut, 1'b1);
        wr(4'h2, 8'h02);
        repeat (3) @(negedge clk);
        check(irqOut, 1'b0);
        $display("Test external reset done");
        @(posedge clk);
        irqPinN <= 1'b0;
        timerReq <= 1'b1;
        repeat (6) @(negedge clk);
        check({extIrqPending, timerIrqPending}, 2'b00);
        @(posedge clk);
        irqPinN <= 1'b1;
        cpuMask <= 1'b0;
        repeat (2) @(negedge clk);
        check({extIrqPending, timerIrqPending}, 2'b11);
        timerReq <= 1'b0;
        repeat (10) @(negedge clk);
        check(extIrqPending, 1'b0);
        wr(4'h1, 8'h04);
        repeat (3) @(negedge clk);
        check(irqOut, 1'b1);
        wr(4'h1, 8'h00);
        repeat (3) @(negedge clk);
        check(irqOut, 1'b0);
        $display("Test interrupts done");
        wr(4'h2, 8'h07);
        wr(4'hC, 8'h50);
        irqPinN <= 1'b0;
        repeat (6) @(posedge clk);
        rd(4'h0, 8'h00);
        irqPinN <= 1'b1;
        repeat (6) @(posedge clk);
        rd(4'h0, 8'h04);
        wr(4'h2, 8'h07);
        wr(4'hC, 8'h40);
        irqPinN <= 1'b0;
        repeat (6) @(posedge clk);
        irqPinN <= 1'b1;
        repeat (6) @(posedge clk);
        rd(4'h0, 8'h00);
        $display("Test pin sensitivity done");
        close_out();
    end
endmodule
